// file: hw/apc_counters.sv
`timescale 1ns/1ps
`include "apc_consts.svh"
module apc_counters
(
  input wire logic clock,
  input wire logic rst,
  input wire logic qualify_en,
  input wire logic [`APC_NUM_ENG-1:0] engine_busy,
  input wire apc_pkg::apc_ev_t vertex_shader_dispatch,
  input wire apc_pkg::apc_ev_t hull_shader_dispatch,
  input wire apc_pkg::apc_ev_t domain_shader_dispatch,
  input wire apc_pkg::apc_ev_t compute_dispatch,
  input wire apc_pkg::apc_ev_t geometry_shader_dispatch,
  input wire apc_pkg::apc_ev_t pixel_shader_dispatch,
  input wire logic [`APC_NUM_EU_EV*`APC_EV_W-1:0] execution_unit_event,
  input wire logic [`APC_SPP_W-1:0] samples_per_pixel,
  input wire apc_pkg::apc_ev_t quad_rasterized,
  input wire apc_pkg::apc_ev_t quad_fail_fast_early,
  input wire apc_pkg::apc_ev_t quad_fail_slow_early,
  input wire apc_pkg::apc_ev_t quad_killed,
  input wire apc_pkg::apc_ev_t quad_fail_late,
  input wire logic rt_update,
  input wire logic [`APC_TGT_W-1:0] rt_target_count,
  input wire apc_pkg::apc_ev_t quad_rt_written,
  input wire apc_pkg::apc_ev_t quad_rt_blended,
  input wire apc_pkg::apc_ev_t sampler_quad_req,
  input wire apc_pkg::apc_ev_t sampler_l1_miss,
  input wire apc_pkg::apc_ev_t shared_local_memory_read,
  input wire apc_pkg::apc_ev_t shared_local_memory_write,
  input wire apc_pkg::apc_ev_t shared_local_memory_atomic,
  input wire apc_pkg::apc_ev_t unified_return_buffer_atomic,
  input wire apc_pkg::apc_ev_t other_mem_req,
  input wire apc_pkg::apc_ev_t other_mem_miss,
  input wire apc_pkg::apc_ev_t barrier_msg,
  input wire logic rd_req,
  input wire logic rd_free,
  input wire logic [`APC_SEL_W-1:0] rd_sel,
  output logic rd_valid,
  output logic rd_err,
  output apc_pkg::apc_count_t rd_data
);
  apc_pkg::apc_inc_t q_inc [0:`APC_NUM_Q-1];
  apc_pkg::apc_inc_t f_inc [0:`APC_NUM_F-1];
  apc_pkg::apc_count_t q_count [0:`APC_NUM_Q-1];
  apc_pkg::apc_count_t f_count [0:`APC_NUM_F-1];
  apc_pkg::apc_inc_t quad_scale;
  apc_pkg::apc_inc_t rt_scale;
  logic rd_valid_q;
  logic rd_valid_d;
  logic rd_err_q;
  logic rd_err_d;
  apc_pkg::apc_count_t rd_data_q;
  apc_pkg::apc_count_t rd_data_d;
  apc_pkg::apc_inc_t quad_ev [0:`APC_NUM_QUAD-1];
  logic [`APC_PROD_W-1:0] quad_prod [0:`APC_NUM_QUAD-1];
  logic [`APC_PROD_W-1:0] rt_prod;
  logic [`APC_PROD_W-1:0] written_prod;
  logic [`APC_PROD_W-1:0] blended_prod;
  logic [`APC_INC_W:0] slm_read_sum;
  logic [`APC_INC_W:0] slm_write_sum;
  logic [`APC_INC_W:0] atomic_sum;
  logic [`APC_NUM_Q-1:0] q_hit;
  logic [`APC_NUM_F-1:0] f_hit;
  apc_pkg::apc_count_t q_part [0:`APC_NUM_Q-1];
  apc_pkg::apc_count_t f_part [0:`APC_NUM_F-1];
  apc_pkg::apc_count_t rd_pick;
  logic rd_hit;

  function automatic apc_pkg::apc_inc_t widen(input apc_pkg::apc_ev_t v);
    widen = {{(`APC_INC_W-`APC_EV_W){1'b0}}, v};
  endfunction : widen

  // full-width operand so products never lose bits before the cut
  function automatic logic [`APC_PROD_W-1:0] grow(input apc_pkg::apc_inc_t v);
    grow = {{(`APC_PROD_W-`APC_INC_W){1'b0}}, v};
  endfunction : grow

  // one unit for every 2x2 counter
  always_comb
  begin
    quad_scale = `APC_INC_ONE;
    if (`APC_QUAD_IN_SAMPLES)
    begin
      quad_scale = {{(`APC_INC_W-`APC_SPP_W){1'b0}}, samples_per_pixel};
    end
  end

  assign rt_prod = grow(quad_scale) * grow({{(`APC_INC_W-`APC_TGT_W){1'b0}}, rt_target_count});
  assign rt_scale = rt_prod[`APC_INC_W-1:0];

  assign q_inc[`APC_A0] = (|engine_busy) ? `APC_INC_ONE : `APC_INC_ZERO;
  assign q_inc[`APC_A1] = widen(vertex_shader_dispatch);
  assign q_inc[`APC_A2] = widen(hull_shader_dispatch);
  assign q_inc[`APC_A3] = widen(domain_shader_dispatch);
  assign q_inc[`APC_A4] = widen(compute_dispatch);
  assign q_inc[`APC_A5] = widen(geometry_shader_dispatch);
  assign q_inc[`APC_A6] = widen(pixel_shader_dispatch);

  generate
    for (genvar e = 0; e < `APC_NUM_EU_EV; e++)
    begin : g_eu_ev
      assign q_inc[`APC_A7+e] = widen(execution_unit_event[e*`APC_EV_W +: `APC_EV_W]);
    end
  endgenerate

  assign quad_ev[0] = widen(quad_rasterized);
  assign quad_ev[1] = widen(quad_fail_fast_early);
  assign quad_ev[2] = widen(quad_fail_slow_early);
  assign quad_ev[3] = widen(quad_killed);
  assign quad_ev[4] = widen(quad_fail_late);

  generate
    for (genvar b = 0; b < `APC_NUM_QUAD; b++)
    begin : g_quad
      assign quad_prod[b] = grow(quad_ev[b]) * grow(quad_scale);
      assign q_inc[`APC_A21+b] = quad_prod[b][`APC_INC_W-1:0];
    end
  endgenerate

  assign written_prod = grow(widen(quad_rt_written)) * grow(rt_scale);
  assign blended_prod = grow(widen(quad_rt_blended)) * grow(rt_scale);
  assign q_inc[`APC_A26] = rt_update ? written_prod[`APC_INC_W-1:0] : `APC_INC_ZERO;
  assign q_inc[`APC_A27] = rt_update ? blended_prod[`APC_INC_W-1:0] : `APC_INC_ZERO;
  assign q_inc[`APC_A28] = widen(sampler_quad_req);
  assign q_inc[`APC_A29] = widen(sampler_l1_miss);
  // atomics add one read and one write
  assign slm_read_sum = {1'b0, widen(shared_local_memory_read)} + {1'b0, widen(shared_local_memory_atomic)};
  assign slm_write_sum = {1'b0, widen(shared_local_memory_write)} + {1'b0, widen(shared_local_memory_atomic)};
  assign q_inc[`APC_A30] = slm_read_sum[`APC_INC_W-1:0];
  assign q_inc[`APC_A31] = slm_write_sum[`APC_INC_W-1:0];
  assign q_inc[`APC_A32] = widen(other_mem_req);
  assign q_inc[`APC_A33] = widen(other_mem_miss);
  assign atomic_sum = {1'b0, widen(shared_local_memory_atomic)} + {1'b0, widen(unified_return_buffer_atomic)};
  assign q_inc[`APC_A34] = atomic_sum[`APC_INC_W-1:0];
  assign q_inc[`APC_A35] = widen(barrier_msg);

  assign f_inc[`APC_F_A4] = q_inc[`APC_A4];
  assign f_inc[`APC_F_A6] = q_inc[`APC_A6];
  assign f_inc[`APC_F_A19] = q_inc[`APC_A19];
  assign f_inc[`APC_F_A20] = q_inc[`APC_A20];

  generate
    for (genvar i = 0; i < `APC_NUM_Q; i++)
    begin : g_qual
      apc_event_cnt u_cnt
      (
        .clock(clock),
        .rst(rst),
        .enable(qualify_en),
        .inc(q_inc[i]),
        .count(q_count[i])
      );
    end
    for (genvar j = 0; j < `APC_NUM_F; j++)
    begin : g_free
      apc_event_cnt u_cnt
      (
        .clock(clock),
        .rst(rst),
        .enable(1'b1),
        .inc(f_inc[j]),
        .count(f_count[j])
      );
    end
  endgenerate

  generate
    for (genvar i = 0; i < `APC_NUM_Q; i++)
    begin : g_qsel
      assign q_hit[i] = !rd_free && (rd_sel == `APC_SEL_W'(i));
      assign q_part[i] = q_hit[i] ? q_count[i] : `APC_CNT_RST;
    end
    for (genvar j = 0; j < `APC_NUM_F; j++)
    begin : g_fsel
      assign f_hit[j] = rd_free && (rd_sel == `APC_SEL_W'(j));
      assign f_part[j] = f_hit[j] ? f_count[j] : `APC_CNT_RST;
    end
  endgenerate

  // unmapped index: no hit, zero data
  always_comb
  begin
    rd_pick = `APC_CNT_RST;
    for (int k = 0; k < `APC_NUM_Q; k++)
    begin
      rd_pick = rd_pick | q_part[k];
    end
    for (int k = 0; k < `APC_NUM_F; k++)
    begin
      rd_pick = rd_pick | f_part[k];
    end
    rd_hit = (|q_hit) | (|f_hit);
  end

  always_comb
  begin
    rd_valid_d = rd_req;
    rd_err_d = 1'b0;
    rd_data_d = rd_data_q;
    if (rd_req)
    begin
      rd_data_d = rd_pick;
      rd_err_d = !rd_hit;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_valid_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= `APC_CNT_RST;
    end
    else
    begin
      rd_valid_q <= rd_valid_d;
      rd_err_q <= rd_err_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_err = rd_err_q;
  assign rd_data = rd_data_q;
endmodule : apc_counters

// file: hw/apc_consts.svh
// How it works
// - A0 counts every clock in which any engine is busy.
// - A1, A2, A3 count vertex, hull, domain shader thread dispatches.
// - A4 counts dispatched general-purpose compute threads.
// - A5, A6 count geometry and pixel shader thread dispatches.
// - A7 to A20 sum fourteen externally selected execution unit events.
// - A4, A6, A19, A20 exist both gated and free-running.
// - A21 counts rasterized 2x2 blocks before any per-pixel test.
// - A21 to A27 share one unit, 2x2 blocks or blocks times samples_per_pixel, fixed at build.
// - A22 counts 2x2 blocks failing fast early tests.
// - A23 counts 2x2 blocks failing slow early tests.
// - A24 counts 2x2 blocks killed by shader kill instructions.
// - A25 counts 2x2 blocks entirely failing late tests.
// - A26 counts render target writes, once per target per block.
// - A27 counts blendable render target writes, every target counted.
// - A26, A27 move only when a render target update really happens.
// - A28 sums 2x2 texel blocks requested from all samplers.
// - A29 sums misses of all first-level sampler caches.
// - A30, A31 count shared local memory reads, writes, atomics included.
// - A32 counts other memory requests, A33 those missing first-level cache.
// - A34 counts atomics to shared local memory and unified return buffer.
// - A35 counts barrier messages, one per thread entering a barrier.
// - Free-running counters need no setup and ignore observation state.
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH
`define APC_CNT_W 40
`define APC_INC_W 20
`define APC_EV_W 8
`define APC_TGT_W 4
`define APC_SPP_W 5
`define APC_SEL_W 6
`define APC_NUM_ENG 8
`define APC_NUM_Q 36
`define APC_NUM_F 4
`define APC_NUM_EU_EV 14
`define APC_PROD_W 40
`define APC_NUM_QUAD 5
`define APC_F_A4 0
`define APC_F_A6 1
`define APC_F_A19 2
`define APC_F_A20 3
`define APC_CNT_RST 40'h00_0000_0000
`define APC_INC_ONE 20'h0_0001
`define APC_INC_ZERO 20'h0_0000
`define APC_QUAD_IN_SAMPLES 1'b0
`define APC_A0 0
`define APC_A1 1
`define APC_A2 2
`define APC_A3 3
`define APC_A4 4
`define APC_A5 5
`define APC_A6 6
`define APC_A7 7
`define APC_A19 19
`define APC_A20 20
`define APC_A21 21
`define APC_A22 22
`define APC_A23 23
`define APC_A24 24
`define APC_A25 25
`define APC_A26 26
`define APC_A27 27
`define APC_A28 28
`define APC_A29 29
`define APC_A30 30
`define APC_A31 31
`define APC_A32 32
`define APC_A33 33
`define APC_A34 34
`define APC_A35 35
`endif

// file: hw/apc_pkg.sv
`include "apc_consts.svh"
package apc_pkg;
  typedef logic [`APC_CNT_W-1:0] apc_count_t;
  typedef logic [`APC_INC_W-1:0] apc_inc_t;
  typedef logic [`APC_EV_W-1:0] apc_ev_t;
endpackage : apc_pkg

// file: hw/apc_event_cnt.sv
`timescale 1ns/1ps
`include "apc_consts.svh"
module apc_event_cnt
(
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire apc_pkg::apc_inc_t inc,
  output apc_pkg::apc_count_t count
);
  apc_pkg::apc_count_t count_q;
  apc_pkg::apc_count_t count_d;
  logic [`APC_CNT_W:0] count_sum;

  always_comb
  begin
    count_sum = {1'b0, count_q} + {{(`APC_CNT_W-`APC_INC_W+1){1'b0}}, inc};
    count_d = count_q;
    if (enable)
    begin
      // carry dropped: count wraps
      count_d = count_sum[`APC_CNT_W-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_q <= `APC_CNT_RST;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule : apc_event_cnt

// file: bench/apc_event_src.sv
`timescale 1ns/1ps
`include "apc_consts.svh"
module apc_event_src
(
  input wire logic clock,
  input wire logic run,
  output logic [287:0] ev,
  output logic [`APC_NUM_ENG-1:0] busy,
  output logic rt_update,
  output logic [`APC_TGT_W-1:0] tgt
);
  always @(negedge clock)
  begin
    for (int k = 0; k < 36; k++)
      ev[k*8+:8] <= run ? 8'($urandom) : 8'h00;
    busy <= (run && $urandom % 2) ? 8'($urandom) : 8'h00;
    rt_update <= run & 1'($urandom);
    tgt <= 4'($urandom);
  end
endmodule : apc_event_src

// file: bench/apc_counters_monitor.sv
`timescale 1ns/1ps
`include "apc_consts.svh"
module apc_counters_monitor
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic rd_free,
  input wire logic [`APC_SEL_W-1:0] rd_sel,
  input wire logic rd_valid,
  input wire logic rd_err,
  input wire apc_pkg::apc_count_t rd_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_lat; rd_req |=> rd_valid; endproperty
  a_lat: assert property (p_lat) else $error("read answer late");
  property p_spur; rd_valid |-> $past(rd_req); endproperty
  a_spur: assert property (p_spur) else $error("answer without request");
  property p_qerr; rd_req && !rd_free |=> rd_err == ($past(rd_sel) >= `APC_NUM_Q); endproperty
  a_qerr: assert property (p_qerr) else $error("qualified index flag wrong");
  property p_ferr; rd_req && rd_free |=> rd_err == ($past(rd_sel) >= `APC_NUM_F); endproperty
  a_ferr: assert property (p_ferr) else $error("free index flag wrong");
  property p_zero; rd_err |-> rd_data == '0; endproperty
  a_zero: assert property (p_zero) else $error("error data not zero");
  property p_hold; !$past(rd_req) |-> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved without read");
  property p_rst; $past(rst) |-> !rd_valid && rd_data == '0; endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_pulse; rd_err |-> rd_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("error without answer");
  c_free: cover property (rd_req && rd_free);
  c_err: cover property (rd_err);
  c_b2b: cover property (rd_valid ##1 rd_valid);
endmodule : apc_counters_monitor
bind apc_counters apc_counters_monitor apc_counters_monitor_i (.clock, .rst, .rd_req, .rd_free, .rd_sel,
  .rd_valid, .rd_err, .rd_data);

// file: bench/test_apc_counters.sv
`timescale 1ns/1ps
`include "apc_consts.svh"
module test_apc_counters;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic qualify_en = 1'b0;
  logic run = 1'b0;
  logic rd_req = 1'b0;
  logic rd_free = 1'b0;
  logic [`APC_SEL_W-1:0] rd_sel = '0;
  logic [287:0] ev;
  logic [`APC_NUM_ENG-1:0] busy;
  logic rt_update;
  logic [`APC_TGT_W-1:0] tgt;
  logic rd_valid;
  logic rd_err;
  apc_pkg::apc_count_t rd_data;
  longint q[36];
  longint f[4];
  longint inc[36];
  int fmap[4] = '{4, 6, 19, 20};
  int error_cnt = 0;
  int samples_checked = 0;
  always #20 clock = ~clock;
  apc_event_src apc_event_src_i (.clock, .run, .ev, .busy, .rt_update, .tgt);
  apc_counters apc_counters_i (.clock, .rst, .qualify_en, .engine_busy(busy),
    .vertex_shader_dispatch(ev[7:0]), .hull_shader_dispatch(ev[15:8]), .domain_shader_dispatch(ev[23:16]),
    .compute_dispatch(ev[31:24]), .geometry_shader_dispatch(ev[39:32]), .pixel_shader_dispatch(ev[47:40]),
    .execution_unit_event(ev[159:48]), .samples_per_pixel(busy[4:0]), .quad_rasterized(ev[167:160]),
    .quad_fail_fast_early(ev[175:168]), .quad_fail_slow_early(ev[183:176]), .quad_killed(ev[191:184]),
    .quad_fail_late(ev[199:192]), .rt_update, .rt_target_count(tgt), .quad_rt_written(ev[207:200]),
    .quad_rt_blended(ev[215:208]), .sampler_quad_req(ev[223:216]), .sampler_l1_miss(ev[231:224]),
    .shared_local_memory_read(ev[239:232]), .shared_local_memory_write(ev[247:240]),
    .shared_local_memory_atomic(ev[255:248]), .unified_return_buffer_atomic(ev[263:256]),
    .other_mem_req(ev[271:264]), .other_mem_miss(ev[279:272]), .barrier_msg(ev[287:280]),
    .rd_req, .rd_free, .rd_sel, .rd_valid, .rd_err, .rd_data);
  always @(posedge clock)
  begin
    inc[0] = |busy;
    for (int n = 1; n < 30; n++)
      inc[n] = ev[(n-1)*8+:8];
    inc[26] = rt_update ? ev[200+:8] * tgt : 0;
    inc[27] = rt_update ? ev[208+:8] * tgt : 0;
    inc[30] = ev[232+:8] + ev[248+:8];
    inc[31] = ev[240+:8] + ev[248+:8];
    inc[32] = ev[264+:8];
    inc[33] = ev[272+:8];
    inc[34] = ev[248+:8] + ev[256+:8];
    inc[35] = ev[280+:8];
    for (int n = 0; n < 36; n++)
      q[n] = rst ? 0 : q[n] + (qualify_en ? inc[n] : 0);
    for (int n = 0; n < 4; n++)
      f[n] = rst ? 0 : f[n] + inc[fmap[n]];
  end
  task automatic chk(input apc_pkg::apc_count_t seen, input apc_pkg::apc_count_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t read %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic fr, input int s);
    logic bad;
    apc_pkg::apc_count_t e;
    bad = fr ? s >= 4 : s >= 36;
    e = bad ? '0 : apc_pkg::apc_count_t'(fr ? f[s] : q[s]);
    rd_req = 1'b1;
    rd_free = fr;
    rd_sel = s[5:0];
    @(negedge clock);
    chk(rd_valid, 1);
    chk(rd_err, bad);
    chk(rd_data, e);
  endtask : rd
  task automatic test_done;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    void'($urandom(13));
    for (int r = 0; r < 2; r++)
    begin
      rd_req = 1'b0;
      run <= 1'b0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      run <= 1'b1;
      qualify_en = 1'b0;
      repeat (20) @(negedge clock);
      for (int i = 0; i < 40; i++)
        rd(i >= 36, i % 36);
      qualify_en = 1'b1;
      repeat (30) @(negedge clock);
      for (int i = 0; i < 7; i++)
        rd(0, i);
      for (int i = 7; i < 21; i++)
        rd(0, i);
      for (int i = 21; i < 28; i++)
        rd(0, i);
      for (int i = 28; i < 36; i++)
        rd(0, i);
      for (int i = 0; i < 6; i++)
        rd(i % 2, i < 2 ? 4 + 32 * i : (i < 4 ? 59 + i : i - 4));
      rst = 1'b1;
    end
    test_done();
  end
endmodule : test_apc_counters
